// ---- lcu_clksel.sv ----
// Purpose: operating clock source select
// Assumes: sel above last source clamps
// Notes: source n ticks every 2**n cycles
`timescale 1ns/1ps
`default_nettype none
`include "lcu_params.svh"
module lcu_clksel (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [3:0] sel,
  // tick
  output logic base_en
);
  logic [10:0] pre;
  logic [10:0] mask;
  logic [3:0] sel_c;
  assign sel_c = (sel > `LCU_SRC_LAST) ? `LCU_SRC_LAST : sel;
  genvar i;
  generate
    for (i = 0; i < 11; i++)
    begin : g_mask
      assign mask[i] = (4'(i) < sel_c);
    end
  endgenerate
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      pre <= 11'h000;
      base_en <= 1'b0;
    end
    else
    begin
      pre <= pre + 11'h001;
      base_en <= ((pre & mask) == mask);
    end
  end
endmodule : lcu_clksel
`default_nettype wire

// ---- lcu_core.sv ----
// Purpose: serial unit with break support, AXI4-Lite registers
// Assumes: one clock, synchronous active-low reset
// Notes: pins sampled as synchronous
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lcu_params.svh"
module lcu_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output lcu_pkg::lcu_byte_t s_axi_rdata_lo,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  output logic serial_tx_out,
  input wire logic serial_rx_in,
  // routed inputs
  input wire logic wakeup_pin_in,
  input wire logic capture_pin_in,
  output logic ext_wakeup_irq,
  output logic capture_timer_input,
  // events
  output logic tx_complete_irq,
  output logic break_irq
);
  import lcu_pkg::*;

  // ****************************************
  // registers and bus
  // ****************************************
  logic [7:0] ctrl;
  logic [3:0] clk_sel;
  logic [7:0] baud_divider_ctrl;
  logic [2:0] brk_len;
  logic [7:0] transmit_holding;
  logic txh_full;
  logic [7:0] receive_holding;
  logic rxh_full;
  logic overrun_flag;
  logic framing_err_flag;
  logic break_flag;
  logic break_err;
  logic [1:0] route;
  logic sbf_req;
  logic aw_got;
  logic w_got;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic wstrb0;
  lcu_rx_if rif ();

  wire unit_power_enable = ctrl[`LCU_B_POWER];
  wire transmit_enable_bit = ctrl[`LCU_B_TXE];
  wire receive_enable_bit = ctrl[`LCU_B_RXE];
  wire tx_run = unit_power_enable && transmit_enable_bit;
  wire rx_run = unit_power_enable && receive_enable_bit;
  wire len8 = ctrl[`LCU_B_LEN8];
  wire msb_first = ctrl[`LCU_B_MSB];

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_fire = aw_got && w_got && !s_axi_bvalid;
  wire next_aw_got = aw_take || (aw_got && !wr_fire);
  wire next_w_got = w_take || (w_got && !wr_fire);
  wire next_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire wr_en = wr_fire && wstrb0;
  wire wr_ctrl = wr_en && (waddr == `LCU_OFF_CTRL);
  wire wr_clk = wr_en && (waddr == `LCU_OFF_CLKSEL);
  wire wr_baud = wr_en && (waddr == `LCU_OFF_BAUD);
  wire wr_brk = wr_en && (waddr == `LCU_OFF_BRKLEN);
  wire wr_txh = wr_en && (waddr == `LCU_OFF_TXH);
  wire wr_stat = wr_en && (waddr == `LCU_OFF_STAT);
  wire wr_cmd = wr_en && (waddr == `LCU_OFF_CMD);
  wire wr_route = wr_en && (waddr == `LCU_OFF_ROUTE);
  wire rd_rxh = ar_take && (s_axi_araddr == `LCU_OFF_RXH);
  wire w_map = (waddr <= `LCU_OFF_ROUTE) && (waddr[1:0] == 2'b00);
  wire r_map = (s_axi_araddr <= `LCU_OFF_ROUTE) && (s_axi_araddr[1:0] == 2'b00);

  // ****************************************
  // transmitter
  // ****************************************
  lcu_tx_state_t tx_state;
  logic [7:0] tx_cnt;
  logic [4:0] tx_bits;
  logic [1:0] gap_cnt;
  logic [7:0] tx_shift;
  logic tx_line;
  logic base_en;
  wire tx_bit_end = base_en && (tx_cnt == baud_divider_ctrl - 8'h01);
  wire [4:0] data_last = {1'b0, len8 ? `LCU_LAST8 : `LCU_LAST7};
  wire [4:0] brk_last = `LCU_SBF_BASE + {2'b00, brk_len} - 5'd1;
  wire tx_msb_bit = len8 ? tx_shift[7] : tx_shift[6];
  wire tx_bit = msb_first ? tx_msb_bit : tx_shift[0];
  wire [7:0] tx_next_shift = msb_first ? {tx_shift[6:0], 1'b1} : {1'b1, tx_shift[7:1]};
  wire tx_load = (tx_state == LCU_TX_IDLE && base_en && txh_full && !sbf_req) ||
                 (tx_state == LCU_TX_GAP && base_en && gap_cnt == `LCU_GAP_TICKS - 2'd1);
  wire tx_done = (tx_state == LCU_TX_STOP) && tx_bit_end;

  lcu_clksel u_clksel (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(unit_power_enable),
    .sel(clk_sel),
    .base_en(base_en)
  );

  // state cleared while power or transmit enable is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_run)
    begin
      tx_state <= LCU_TX_IDLE;
      tx_cnt <= 8'h00;
      tx_bits <= 5'd0;
      gap_cnt <= 2'd0;
      tx_shift <= `LCU_HOLD_RST;
      tx_line <= 1'b1;
    end
    else
    begin
      if (base_en)
        tx_cnt <= tx_bit_end ? 8'h00 : tx_cnt + 8'h01;
      case (tx_state)
        LCU_TX_IDLE:
        begin
          tx_cnt <= 8'h00;
          tx_bits <= 5'd0;
          // start on a base tick, whole first bit
          if (sbf_req && base_en)
          begin
            tx_state <= LCU_TX_BRK;
            tx_line <= 1'b0;
          end
          else if (tx_load)
          begin
            tx_state <= LCU_TX_START;
            tx_shift <= transmit_holding;
            tx_line <= 1'b0;
          end
        end
        LCU_TX_START:
          if (tx_bit_end)
          begin
            tx_state <= LCU_TX_DATA;
            tx_line <= tx_bit;
          end
        LCU_TX_DATA:
          if (tx_bit_end)
          begin
            tx_shift <= tx_next_shift;
            tx_bits <= tx_bits + 5'd1;
            tx_line <= (tx_bits == data_last) ? 1'b1 : (msb_first ?
                       (len8 ? tx_shift[6] : tx_shift[5]) : tx_shift[1]);
            if (tx_bits == data_last)
              tx_state <= LCU_TX_STOP;
          end
        LCU_TX_BRK:
          if (tx_bit_end)
          begin
            tx_bits <= tx_bits + 5'd1;
            if (tx_bits == brk_last)
            begin
              tx_state <= LCU_TX_STOP;
              tx_line <= 1'b1;
            end
          end
        LCU_TX_STOP:
          if (tx_bit_end)
          begin
            tx_bits <= 5'd0;
            gap_cnt <= 2'd0;
            tx_state <= txh_full ? LCU_TX_GAP : LCU_TX_IDLE;
          end
        LCU_TX_GAP:
          if (base_en)
          begin
            gap_cnt <= gap_cnt + 2'd1;
            if (tx_load)
            begin
              tx_state <= LCU_TX_START;
              tx_shift <= transmit_holding;
              tx_line <= 1'b0;
              tx_cnt <= 8'h00;
            end
          end
        default: tx_state <= LCU_TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // receiver link
  // ****************************************
  assign rif.base_en = base_en;
  assign rif.div_k = baud_divider_ctrl;
  assign rif.run = rx_run;
  assign rif.len8 = len8;
  assign rif.msb_first = msb_first;
  assign rif.brk_arm = wr_cmd && wdata[`LCU_B_CMD_ARM];
  assign rif.rx_line = unit_power_enable ? serial_rx_in : 1'b1;

  lcu_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif)
  );

  wire rx_over = rif.done && rxh_full;
  wire rx_xfer = rif.done && !rxh_full;

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `LCU_CTRL_RST;
      clk_sel <= 4'h0;
      baud_divider_ctrl <= `LCU_BAUD_RST;
      brk_len <= 3'd0;
      route <= 2'b00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {wdata[7:2], 2'b00};
      if (wr_clk)
        clk_sel <= wdata[3:0];
      if (wr_baud)
        baud_divider_ctrl <= wdata;
      if (wr_brk)
        brk_len <= wdata[2:0];
      if (wr_route)
        route <= wdata[1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_run)
    begin
      txh_full <= 1'b0;
      sbf_req <= 1'b0;
    end
    else
    begin
      if (wr_txh)
        txh_full <= 1'b1;
      else if (tx_load)
        txh_full <= 1'b0;
      if (wr_cmd && wdata[`LCU_B_CMD_SBF])
        sbf_req <= 1'b1;
      else if (tx_state == LCU_TX_BRK)
        sbf_req <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      transmit_holding <= `LCU_HOLD_RST;
    else if (wr_txh)
      transmit_holding <= wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !unit_power_enable)
    begin
      receive_holding <= `LCU_HOLD_RST;
      rxh_full <= 1'b0;
    end
    else
    begin
      if (rx_xfer)
        receive_holding <= rif.data;
      if (rx_xfer)
        rxh_full <= 1'b1;
      else if (rd_rxh)
        rxh_full <= 1'b0;
    end
  end

  // status bits: write one clears, a new event wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !unit_power_enable)
    begin
      overrun_flag <= 1'b0;
      framing_err_flag <= 1'b0;
      break_flag <= 1'b0;
      break_err <= 1'b0;
    end
    else
    begin
      overrun_flag <= rx_over || (overrun_flag && !(wr_stat && wdata[0]));
      framing_err_flag <= (rx_xfer && rif.frame_err) || (framing_err_flag && !(wr_stat && wdata[1]));
      break_flag <= rif.brk_ok || (break_flag && !(wr_stat && wdata[2]));
      break_err <= rif.brk_err || (break_err && !(wr_stat && wdata[3]));
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_tx_out <= 1'b1;
      tx_complete_irq <= 1'b0;
      break_irq <= 1'b0;
      ext_wakeup_irq <= 1'b1;
      capture_timer_input <= 1'b1;
    end
    else
    begin
      serial_tx_out <= unit_power_enable ? (tx_line ^ ctrl[`LCU_B_INV]) : 1'b1;
      tx_complete_irq <= tx_done;
      break_irq <= rif.brk_ok;
      ext_wakeup_irq <= route[`LCU_B_WAKE] ? serial_rx_in : wakeup_pin_in;
      capture_timer_input <= route[`LCU_B_CAPT] ? serial_rx_in : capture_pin_in;
    end
  end

  // ****************************************
  // bus handshake
  // ****************************************
  wire [7:0] stat = {rif.brk_mode, rxh_full, tx_state != LCU_TX_IDLE, txh_full,
                     break_err, break_flag, framing_err_flag, overrun_flag};
  wire [7:0] rd_sel =
    (s_axi_araddr == `LCU_OFF_CTRL) ? ctrl :
    (s_axi_araddr == `LCU_OFF_CLKSEL) ? {4'h0, clk_sel} :
    (s_axi_araddr == `LCU_OFF_BAUD) ? baud_divider_ctrl :
    (s_axi_araddr == `LCU_OFF_BRKLEN) ? {5'h00, brk_len} :
    (s_axi_araddr == `LCU_OFF_TXH) ? transmit_holding :
    (s_axi_araddr == `LCU_OFF_RXH) ? receive_holding :
    (s_axi_araddr == `LCU_OFF_STAT) ? stat :
    (s_axi_araddr == `LCU_OFF_ROUTE) ? {6'h00, route} : 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCU_RESP_OK;
    end
    else
    begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready <= !next_w_got && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (wr_fire)
        s_axi_bresp <= w_map ? `LCU_RESP_OK : `LCU_RESP_ERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      waddr <= 8'h00;
      wdata <= 8'h00;
      wstrb0 <= 1'b0;
    end
    else
    begin
      if (aw_take)
        waddr <= s_axi_awaddr;
      if (w_take)
        wdata <= s_axi_wdata[7:0];
      if (w_take)
        wstrb0 <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata_lo <= 8'h00;
      s_axi_rresp <= `LCU_RESP_OK;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata_lo <= rd_sel;
        s_axi_rresp <= r_map ? `LCU_RESP_OK : `LCU_RESP_ERR;
      end
    end
  end
endmodule : lcu_core
`default_nettype wire

// ---- lcu_core_chk.sv ----
// Purpose: port checks of the serial unit
// Assumes: one clock
// Notes: bound to lcu_core
`timescale 1ns/1ps
`default_nettype none
module lcu_core_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic serial_tx_out,
  input wire logic serial_rx_in,
  input wire logic wakeup_pin_in,
  input wire logic capture_pin_in,
  input wire logic ext_wakeup_irq,
  input wire logic capture_timer_input,
  input wire logic tx_complete_irq,
  input wire logic break_irq
);
  int low_run;
  int last_low;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // **********
  // checks
  // **********
  always_ff @(posedge aclk)
  begin
    low_run <= serial_rx_in ? 0 : low_run + 1;
    if (serial_rx_in && low_run > 0)
      last_low <= low_run;
  end
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer twice");
  tx_pulse_a: assert property (tx_complete_irq |=> !tx_complete_irq)
    else $error("long tx pulse");
  brk_pulse_a: assert property (break_irq |=> !break_irq)
    else $error("long break pulse");
  brk_len_a: assert property (break_irq |-> last_low >= 22)
    else $error("break after short low");
  wake_route_a: assert property ($past(aresetn) && $past(aresetn, 2) |->
    ext_wakeup_irq == $past(wakeup_pin_in) || ext_wakeup_irq == $past(serial_rx_in))
    else $error("wakeup route wrong");
  capt_route_a: assert property ($past(aresetn) && $past(aresetn, 2) |->
    capture_timer_input == $past(capture_pin_in) || capture_timer_input == $past(serial_rx_in))
    else $error("capture route wrong");
  rst_idle_a: assert property (disable iff (1'h0) !aresetn |=> serial_tx_out && !break_irq)
    else $error("line not idle in reset");
endmodule : lcu_core_chk
bind lcu_core lcu_core_chk chk_i (.*);
`default_nettype wire

// ---- lcu_params.svh ----
// Purpose: constants for the serial unit
// Assumes: included by bare name
// Notes: byte offsets on the register bus
`ifndef LCU_PARAMS_SVH
`define LCU_PARAMS_SVH
`define LCU_OFF_CTRL 8'h00
`define LCU_OFF_CLKSEL 8'h04
`define LCU_OFF_BAUD 8'h08
`define LCU_OFF_BRKLEN 8'h0c
`define LCU_OFF_TXH 8'h10
`define LCU_OFF_RXH 8'h14
`define LCU_OFF_STAT 8'h18
`define LCU_OFF_CMD 8'h1c
`define LCU_OFF_ROUTE 8'h20
`define LCU_CTRL_RST 8'h10
`define LCU_BAUD_RST 8'h10
`define LCU_HOLD_RST 8'hff
`define LCU_B_POWER 7
`define LCU_B_TXE 6
`define LCU_B_RXE 5
`define LCU_B_LEN8 4
`define LCU_B_MSB 3
`define LCU_B_INV 2
`define LCU_B_CMD_SBF 0
`define LCU_B_CMD_ARM 1
`define LCU_B_WAKE 0
`define LCU_B_CAPT 1
`define LCU_SBF_BASE 5'd13
`define LCU_BRK_MIN 4'd11
`define LCU_GAP_TICKS 2'd2
`define LCU_LAST8 4'd7
`define LCU_LAST7 4'd6
`define LCU_SRC_LAST 4'd11
`define LCU_RESP_OK 2'b00
`define LCU_RESP_ERR 2'b10
`endif

// ---- lcu_pkg.sv ----
// Purpose: shared types of the serial unit
// Assumes: nothing
// Notes: binary state codes
package lcu_pkg;
  typedef enum logic [2:0] {
    LCU_TX_IDLE = 3'b000,
    LCU_TX_START = 3'b001,
    LCU_TX_DATA = 3'b010,
    LCU_TX_STOP = 3'b011,
    LCU_TX_GAP = 3'b100,
    LCU_TX_BRK = 3'b101
  } lcu_tx_state_t;
  typedef enum logic [2:0] {
    LCU_RX_IDLE = 3'b000,
    LCU_RX_START = 3'b001,
    LCU_RX_DATA = 3'b010,
    LCU_RX_STOP = 3'b011,
    LCU_RX_BRK = 3'b100
  } lcu_rx_state_t;
  typedef logic [7:0] lcu_byte_t;
endpackage : lcu_pkg

// ---- lcu_remote.sv ----
// Purpose: remote serial node
// Assumes: bit time BT clocks
// Notes: line idles high
`timescale 1ns/1ps
`default_nettype none
module lcu_remote #(
  parameter int BT = 4
) (
  // clock
  input wire logic aclk,
  // line
  input wire logic line_in,
  output logic line_out
);
  // **********
  // frames
  // **********
  initial line_out = 1'h1;
  task automatic hold(input logic b, input int k);
    line_out <= b;
    repeat (k) @(posedge aclk);
  endtask : hold
  task automatic send(input logic [7:0] x, input int nb, input int msb);
    int i;
    hold(1'h0, BT);
    for (i = 0; i < nb; i++)
      hold(x[msb ? nb - 1 - i : i], BT);
    hold(1'h1, 2 * BT);
  endtask : send
  task automatic low_wait();
    int i;
    for (i = 0; i < 9999 && line_in !== 1'h0; i++)
      @(posedge aclk);
  endtask : low_wait
  task automatic recv(output logic [7:0] x, input int nb, input int msb);
    int i;
    x = 8'h00;
    low_wait();
    repeat (BT / 2) @(posedge aclk);
    for (i = 0; i < nb; i++)
    begin
      repeat (BT) @(posedge aclk);
      x[msb ? nb - 1 - i : i] = line_in;
    end
  endtask : recv
  task automatic low_len(output int k);
    k = 0;
    low_wait();
    while (line_in === 1'h0 && k < 9999)
    begin
      @(posedge aclk);
      k++;
    end
  endtask : low_len
endmodule : lcu_remote
`default_nettype wire

// ---- lcu_rx.sv ----
// Purpose: serial receiver with break detection
// Assumes: bit time of div_k base ticks
// Notes: samples mid-bit
`timescale 1ns/1ps
`default_nettype none
`include "lcu_params.svh"
module lcu_rx (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core side
  lcu_rx_if.rx rif
);
  import lcu_pkg::*;
  lcu_rx_state_t state;
  logic [7:0] cnt;
  logic [3:0] bits;
  logic [3:0] low_bits;
  logic [7:0] receive_shifter;
  wire [7:0] half = {1'b0, rif.div_k[7:1]};
  wire [7:0] k_last = rif.div_k - 8'h01;
  wire [3:0] last = rif.len8 ? `LCU_LAST8 : `LCU_LAST7;
  wire bit_end = rif.base_en && (cnt == k_last);
  wire [7:0] shl = {receive_shifter[6:0], rif.rx_line};
  wire [7:0] shr = {rif.rx_line, receive_shifter[7:1]};
  wire [7:0] shifted = rif.msb_first ? shl : shr;
  wire [7:0] asm7 = rif.msb_first ? {receive_shifter[6:0], 1'b0} : {1'b0, receive_shifter[7:1]};
  wire [7:0] assembled = rif.len8 ? receive_shifter : asm7;
  wire brk_good = (low_bits >= `LCU_BRK_MIN);
  always_ff @(posedge aclk)
  begin
    rif.done <= 1'b0;
    rif.brk_ok <= 1'b0;
    rif.brk_err <= 1'b0;
    if (!aresetn || !rif.run)
    begin
      state <= LCU_RX_IDLE;
      cnt <= 8'h00;
      bits <= 4'h0;
      low_bits <= 4'h0;
      receive_shifter <= `LCU_HOLD_RST;
      rif.brk_mode <= 1'b0;
      rif.data <= `LCU_HOLD_RST;
      rif.frame_err <= 1'b0;
    end
    else
    begin
      if (rif.brk_arm)
        rif.brk_mode <= 1'b1;
      if (rif.base_en)
        cnt <= bit_end ? 8'h00 : cnt + 8'h01;
      case (state)
        LCU_RX_IDLE:
        begin
          cnt <= 8'h00;
          bits <= 4'h0;
          low_bits <= 4'h0;
          if (!rif.rx_line)
            state <= rif.brk_mode ? LCU_RX_BRK : LCU_RX_START;
        end
        LCU_RX_START:
          if (rif.base_en && cnt == half)
          begin
            cnt <= 8'h00;
            state <= rif.rx_line ? LCU_RX_IDLE : LCU_RX_DATA;
          end
        LCU_RX_DATA:
          if (bit_end)
          begin
            receive_shifter <= shifted;
            bits <= bits + 4'h1;
            if (bits == last)
              state <= LCU_RX_STOP;
          end
        LCU_RX_STOP:
          if (bit_end)
          begin
            rif.done <= 1'b1;
            rif.data <= assembled;
            rif.frame_err <= !rif.rx_line;
            state <= LCU_RX_IDLE;
          end
        LCU_RX_BRK:
        begin
          receive_shifter <= `LCU_HOLD_RST;
          if (bit_end && low_bits != 4'hf)
            low_bits <= low_bits + 4'h1;
          if (rif.rx_line)
          begin
            rif.brk_ok <= brk_good;
            rif.brk_err <= !brk_good;
            rif.brk_mode <= !brk_good;
            state <= LCU_RX_IDLE;
          end
        end
        default: state <= LCU_RX_IDLE;
      endcase
    end
  end
endmodule : lcu_rx
`default_nettype wire

// ---- lcu_rx_if.sv ----
// Purpose: carrier between core and receiver
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface lcu_rx_if;
  logic base_en;
  logic [7:0] div_k;
  logic run;
  logic len8;
  logic msb_first;
  logic brk_arm;
  logic rx_line;
  logic done;
  logic [7:0] data;
  logic frame_err;
  logic brk_ok;
  logic brk_err;
  logic brk_mode;
  modport core (output base_en, div_k, run, len8, msb_first, brk_arm, rx_line,
                input done, data, frame_err, brk_ok, brk_err, brk_mode);
  modport rx (input base_en, div_k, run, len8, msb_first, brk_arm, rx_line,
              output done, data, frame_err, brk_ok, brk_err, brk_mode);
endinterface : lcu_rx_if
`default_nettype wire

// ---- tb_lin_capable_uart.sv ----
// Purpose: self-checking bench
// Assumes: bit time BT clocks
// Notes: remote node on serial pins
`timescale 1ns/1ps
`default_nettype none
`include "lcu_params.svh"
module tb_lin_capable_uart;
  localparam int BT = 4;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic wakeup_pin_in = 1'h1, capture_pin_in = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d, v;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_rx_in, serial_tx_out, ext_wakeup_irq, capture_timer_input;
  logic tx_complete_irq, break_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  lcu_pkg::lcu_byte_t s_axi_rdata_lo;
  int tests_run = 0, miscompares = 0, ntx = 0, nbrk = 0, seed = 32'h1b5a, m, n, t, c;
  int q[$];
  // **********
  // harness
  // **********
  lcu_core uut (.*);
  lcu_remote #(.BT(BT)) rem (.aclk(aclk), .line_in(serial_tx_out), .line_out(serial_rx_in));
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    ntx += (tx_complete_irq === 1'h1);
    nbrk += (break_irq === 1'h1);
  end
  initial
  begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic finish_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, x};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 99 && !(s_axi_bready && s_axi_bvalid); i++)
    begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 99 && !(s_axi_rready && s_axi_rvalid); i++)
    begin
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end
    v = s_axi_rdata_lo;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wtx(input int e);
    int i;
    for (i = 0; i < 999 && ntx < e; i++)
      @(posedge aclk);
  endtask : wtx
  // **********
  // scenarios
  // **********
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    wr(`LCU_OFF_RXH, 8'h00);
    rd(`LCU_OFF_RXH);
    chk("hold", v, 8'hff);
    rd(8'h40);
    chk("unmapped", resp, 2'h2);
    wr(`LCU_OFF_BAUD, BT);
    for (m = 0; m < 4; m++)
    begin
      wr(`LCU_OFF_ROUTE, m);
      wakeup_pin_in <= $random(seed);
      capture_pin_in <= $random(seed);
      repeat (3) @(posedge aclk);
      chk("wake", ext_wakeup_irq, m[0] ? serial_rx_in : wakeup_pin_in);
      chk("capt", capture_timer_input, m[1] ? serial_rx_in : capture_pin_in);
    end
    for (m = 0; m < 4; m++)
    begin
      n = m[1] ? 8 : 7;
      wr(`LCU_OFF_CTRL, 8'he0 + 16 * m[1] + 8 * m[0]);
      d = m == 2 ? 8'h80 : $random(seed);
      t = ntx;
      fork
        rem.recv(v, n, m[0]);
        wr(`LCU_OFF_TXH, d);
      join
      wtx(t + 1);
      chk("tx", v, n == 8 ? d : d & 8'h7f);
      chk("txc", ntx, t + 1);
      d = $random(seed);
      rem.send(d, n, m[0]);
      rem.send($random(seed), n, m[0]);
      q.push_back(n == 8 ? d : m[0] ? {d[6:0], 1'h0} : d & 8'h7f);
      rd(`LCU_OFF_RXH);
      c = q.pop_front();
      chk("rx", v, c);
    end
    t = nbrk;
    wr(`LCU_OFF_CMD, 8'h02);
    rem.hold(1'h0, 12 * BT);
    rem.hold(1'h1, 4 * BT);
    chk("brk", nbrk, t + 1);
    wr(`LCU_OFF_CMD, 8'h02);
    rem.hold(1'h0, 8 * BT);
    rem.hold(1'h1, 4 * BT);
    chk("brk_short", nbrk, t + 1);
    rd(`LCU_OFF_RXH);
    chk("brk_hold", v, c);
    for (m = 0; m < 2; m++)
    begin
      wr(`LCU_OFF_CLKSEL, m);
      wr(`LCU_OFF_BRKLEN, 7 * m);
      t = ntx;
      fork
        rem.low_len(n);
        wr(`LCU_OFF_CMD, 8'h01);
      join
      wtx(t + 1);
      chk("sbf_len", n, (13 + 7 * m) * BT << m);
      chk("sbf_done", ntx, t + 1);
    end
    wr(`LCU_OFF_CTRL, 8'he4);
    repeat (2) @(posedge aclk);
    chk("inv_idle", serial_tx_out, 1'h0);
    wr(`LCU_OFF_CTRL, 8'h04);
    repeat (2) @(posedge aclk);
    chk("off_idle", serial_tx_out, 1'h1);
    rd(`LCU_OFF_RXH);
    chk("off_hold", v, 8'hff);
    finish_test();
  end
endmodule : tb_lin_capable_uart
`default_nettype wire
